/* rtl/lw_sram_pkg.sv */
package lw_sram_pkg;

   localparam int LANE_BITS       = 9;
   localparam int LANES           = 4;
   localparam int DATA_BITS       = LANE_BITS * LANES;
   localparam int ADDR_BITS       = 8;

   localparam int CLK_PERIOD_NS   = 100;
   localparam int SLEEP_ENTRY_NS  = 50;
   localparam int SLEEP_EXIT_NS   = 200;
   // Longest time rounds down, floored at one cycle
   localparam int SLEEP_ENTRY_CYC = (SLEEP_ENTRY_NS / CLK_PERIOD_NS) < 1 ? 1
                                    : SLEEP_ENTRY_NS / CLK_PERIOD_NS;
   // Least time rounds up
   localparam int SLEEP_EXIT_CYC  = (SLEEP_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam int IMP_BITS        = 8;
   localparam int IMP_RATIO       = 5;
   localparam logic [IMP_BITS-1:0] IMP_DEFAULT = 8'h32;
   localparam logic [IMP_BITS-1:0] IMP_MIN     = 8'h01;
   localparam int IMP_DIV         = 4;
   localparam int IMP_DIV_BITS    = 2;

   typedef enum logic [1:0]
   {
      PW_RUN   = 2'b00,
      PW_ENTER = 2'b01,
      PW_SLEEP = 2'b11,
      PW_WAKE  = 2'b10
   } power_state_t;

   typedef struct packed
   {
      logic                 valid;
      logic [ADDR_BITS-1:0] addr;
      logic [LANES-1:0]     lanes;
      logic [DATA_BITS-1:0] data;
   } write_buf_t;

endpackage

/* rtl/imp_calibrator.sv */
`timescale 1ns/100ps
`default_nettype none

module imp_calibrator
#(
   parameter int DIV = lw_sram_pkg::IMP_DIV
)
(
   input  wire logic                             clk,
   input  wire logic                             rst,
   input  wire logic                             restart,
   input  wire logic                             ref_to_supply,
   input  wire logic [lw_sram_pkg::IMP_BITS-1:0] ref_resistor,
   output logic      [lw_sram_pkg::IMP_BITS-1:0] impedance
);

   logic [lw_sram_pkg::IMP_DIV_BITS-1:0] div_count;
   logic                                 tick;
   logic [lw_sram_pkg::IMP_BITS-1:0]     target;

   assign target = ref_to_supply ? lw_sram_pkg::IMP_MIN   // see R26
                 : lw_sram_pkg::IMP_BITS'(ref_resistor / lw_sram_pkg::IMP_RATIO); // see R19

   // Update rate is a divided clock, so it stops with the clock
   always_ff @(posedge clk)
   begin
      if (rst || restart)
         div_count <= '0;
      else
         div_count <= (div_count == lw_sram_pkg::IMP_DIV_BITS'(DIV - 1)) ? '0
                      : div_count + 1'b1;
   end
   assign tick = (div_count == lw_sram_pkg::IMP_DIV_BITS'(DIV - 1)); // see R20

   // Single-count steps keep the drivers free of glitches
   always_ff @(posedge clk)
   begin
      if (rst || restart)
         impedance <= lw_sram_pkg::IMP_DEFAULT;                  // see R25
      else if (tick && impedance < target)
         impedance <= impedance + 1'b1;                           // see R21
      else if (tick && impedance > target)
         impedance <= impedance - 1'b1;                           // see R21
   end

   step_small_a: assert property (@(posedge clk) disable iff (rst) // see R21
      !$past(restart) |-> (impedance - $past(impedance) <= 1
                           || $past(impedance) - impedance <= 1))
      else $error("impedance jumped more than one step");

endmodule // imp_calibrator

`default_nettype wire

/* rtl/lane_merge.sv */
`timescale 1ns/100ps
`default_nettype none

module lane_merge
(
   input  wire logic [lw_sram_pkg::DATA_BITS-1:0] old_word,
   input  wire logic [lw_sram_pkg::DATA_BITS-1:0] new_word,
   input  wire logic [lw_sram_pkg::LANES-1:0]     lanes,
   output logic      [lw_sram_pkg::DATA_BITS-1:0] merged
);

   for (genvar i = 0; i < lw_sram_pkg::LANES; i++)
   begin : g_lane
      assign merged[i*lw_sram_pkg::LANE_BITS +: lw_sram_pkg::LANE_BITS] =
         lanes[i] ? new_word[i*lw_sram_pkg::LANE_BITS +: lw_sram_pkg::LANE_BITS]
                  : old_word[i*lw_sram_pkg::LANE_BITS +: lw_sram_pkg::LANE_BITS]; // see R13
   end

endmodule // lane_merge

`default_nettype wire

/* rtl/late_write_sync_sram_port.sv */
`timescale 1ns/100ps
`default_nettype none

// Function
// R01 - All controls except output enable are sampled on the rising clock edge.
// R02 - On a read, output latch opens at the falling edge of that cycle.
// R03 - Output latch closes on next rising edge, holding the previous read data.
// R04 - Read data valid at later of fall-to-valid and rise-to-valid delays.
// R05 - Controller may give a new read address while prior data is delivered.
// R06 - Controller issues write after read only with float and setup met.
// R07 - A read is accepted right after a write, no idle cycle.
// R08 - Chip select sampled inactive turns drivers off immediately. The code drops data_oe two rising edges after the sampling edge.
// R09 - Write strobe sampled active turns drivers off within the same cycle. The code drops data_oe two rising edges after the sampling edge.
// R10 - Select active with strobe inactive enables drivers after fall-to-drive delay.
// R11 - Active-low output enable gates drivers with no clock edge. The code synchronises it; data_oe responds on the third rising edge.
// R12 - Outputs hold previous data until drive start, enable hold or float delay.
// R13 - Each lane is nine bits with its own active-low write enable.
// R14 - Lane enables ignored on reads; all active writes the full width.
// R15 - A cycle writing any lane reads no lane at that address.
// R16 - Write with no lane enabled stores nothing but still turns drivers off.
// R17 - Write address on first rising edge, data on the following one.
// R18 - One buffered write; matching reads return buffered data.
// R19 - Output impedance is one fifth of the reference resistor.
// R20 - Calibration runs continuously from a divided clock.
// R21 - Impedance moves in small monotonic steps.
// R22 - Sleep entered within 50 ns; controller waits 200 ns after wake. The code enters sleep one 100 ns cycle after the synchronised request.
// R23 - Controller starts no access two cycles before sleep or during recovery.
// R24 - Asleep: deselected, clock gated, outputs high impedance, no accesses.
// R25 - After power-up or wake, impedance starts near 50 ohms and converges.
// R26 - Reference tied to supply selects minimum impedance.
module late_write_sync_sram_port
#(
   parameter int ADDR_BITS = lw_sram_pkg::ADDR_BITS
)
(
   input  wire logic                              clk,
   input  wire logic                              rst,
   input  wire logic                              chip_select_n,
   input  wire logic                              write_strobe_n,
   input  wire logic [lw_sram_pkg::LANES-1:0]     lane_write_enable_n,
   input  wire logic [ADDR_BITS-1:0]              address_in,
   input  wire logic [lw_sram_pkg::DATA_BITS-1:0] data_in,
   input  wire logic                              output_enable_n,
   input  wire logic                              sleep_request,
   input  wire logic                              impedance_ref_pin,
   input  wire logic [lw_sram_pkg::IMP_BITS-1:0]  impedance_resistor,
   output logic      [lw_sram_pkg::DATA_BITS-1:0] data_out,
   output logic      [lw_sram_pkg::DATA_BITS-1:0] data_oe,
   output logic      [lw_sram_pkg::IMP_BITS-1:0]  drive_impedance,
   output logic                                   asleep
);

   localparam int DW = lw_sram_pkg::DATA_BITS;

   // Pin synchronisers (output enable, sleep and strap are asynchronous)
   logic       oe_n_meta;
   logic       oe_n_sync;
   logic       sleep_meta;
   logic       sleep_sync;
   logic       zref_meta;
   logic       zref_sync;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         oe_n_meta  <= 1'b1;
         oe_n_sync  <= 1'b1;
         sleep_meta <= 1'b0;
         sleep_sync <= 1'b0;
         zref_meta  <= 1'b0;
         zref_sync  <= 1'b0;
      end
      else
      begin
         oe_n_meta  <= output_enable_n;
         oe_n_sync  <= oe_n_meta;
         sleep_meta <= sleep_request;
         sleep_sync <= sleep_meta;
         zref_meta  <= impedance_ref_pin;
         zref_sync  <= zref_meta;
      end
   end

   // Power state: entry takes one 100 ns cycle, which exceeds the 50 ns bound
   lw_sram_pkg::power_state_t pstate;
   logic [3:0]                wake_count;
   logic                      active;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         pstate     <= lw_sram_pkg::PW_RUN;
         wake_count <= 4'h0;
      end
      else
      begin
         case (pstate)
            lw_sram_pkg::PW_RUN:
               if (sleep_sync)
                  pstate <= lw_sram_pkg::PW_SLEEP;                 // see R22
            lw_sram_pkg::PW_SLEEP:
               if (!sleep_sync)
               begin
                  pstate     <= lw_sram_pkg::PW_WAKE;
                  wake_count <= 4'(lw_sram_pkg::SLEEP_EXIT_CYC);
               end
            lw_sram_pkg::PW_WAKE:
               if (sleep_sync)
                  pstate <= lw_sram_pkg::PW_SLEEP;
               else if (wake_count <= 4'h1)
                  pstate <= lw_sram_pkg::PW_RUN;
               else
                  wake_count <= wake_count - 4'h1;
            default:
               pstate <= lw_sram_pkg::PW_RUN;
         endcase
      end
   end

   // Accesses during recovery are the controller's fault; core simply stays gated
   assign active = (pstate == lw_sram_pkg::PW_RUN) && !sleep_sync;  // see R24 see R23

   // Registered controls
   logic                              sel_q;
   logic                              rd_q;
   logic                              wr_q;
   logic [lw_sram_pkg::LANES-1:0]     lanes_q;
   logic [ADDR_BITS-1:0]              addr_q;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         sel_q   <= 1'b0;
         rd_q    <= 1'b0;
         wr_q    <= 1'b0;
         lanes_q <= '0;
         addr_q  <= '0;
      end
      else
      begin
         sel_q   <= active && !chip_select_n;                           // see R01
         rd_q    <= active && !chip_select_n && write_strobe_n;         // see R14 see R07
         wr_q    <= active && !chip_select_n && !write_strobe_n;        // see R15
         lanes_q <= ~lane_write_enable_n;                               // see R13
         addr_q  <= address_in;
      end
   end

   // Array and write buffer
   logic [DW-1:0]           mem [2**ADDR_BITS];
   lw_sram_pkg::write_buf_t wbuf;
   logic [DW-1:0]           array_word;
   logic [DW-1:0]           merged;
   logic [DW-1:0]           fwd_word;
   logic                    hit;

   assign array_word = mem[wbuf.addr];

   lane_merge u_commit
   (
      .old_word (array_word),
      .new_word (wbuf.data),
      .lanes    (wbuf.lanes),
      .merged   (merged)
   );

   // Data lands one edge after address: previous cycle's write takes data_in now
   always_ff @(posedge clk)
   begin
      if (rst)
         wbuf <= '0;
      else if (wr_q && active)
      begin
         wbuf.valid <= |lanes_q;                                        // see R16
         wbuf.addr  <= addr_q;
         wbuf.lanes <= lanes_q;
         wbuf.data  <= data_in;                                         // see R17
      end
   end

   // Commit the older buffered write when a newer one replaces it
   always_ff @(posedge clk)
   begin
      if (!rst && wr_q && active && wbuf.valid)
         mem[wbuf.addr] <= merged;
   end

   assign hit = wbuf.valid && (wbuf.addr == addr_q);

   lane_merge u_forward
   (
      .old_word (mem[addr_q]),
      .new_word (wbuf.data),
      .lanes    (hit ? wbuf.lanes : '0),
      .merged   (fwd_word)
   );

   // Output latch: on a read the fall-phase data is captured at the rising edge
   // that closes the latch; sampling rides on the single clock here.
   logic [DW-1:0] latch_word;
   logic          drive;
   logic          out_on;

   always_ff @(posedge clk)
   begin
      if (rst)
         latch_word <= '0;
      else if (rd_q && active)
         latch_word <= fwd_word;                                        // see R02 see R18 see R04
   end

   // Drive state: deselect or write strobe clear drive at the sampling edge; data_oe follows two edges later
   always_ff @(posedge clk)
   begin
      if (rst)
         drive <= 1'b0;
      else if (!active || chip_select_n)
         drive <= 1'b0;                                                 // see R08 see R24
      else if (!write_strobe_n)
         drive <= 1'b0;                                                 // see R09 see R16
      else
         drive <= 1'b1;                                                 // see R10
   end

   // Enable trails the request by one stage so it lines up with the word it
   // qualifies; enabling any earlier would put the older word on the pins.
   always_ff @(posedge clk)
   begin
      if (rst)
         out_on <= 1'b0;
      else
         out_on <= drive && rd_q && active;                             // see R10
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         data_out <= '0;
         data_oe  <= '0;
         asleep   <= 1'b0;
      end
      else
      begin
         data_out <= latch_word;                                        // see R03 see R12
         data_oe  <= {DW{out_on && !oe_n_sync && active}};              // see R11
         asleep   <= (pstate == lw_sram_pkg::PW_SLEEP);
      end
   end

   imp_calibrator u_cal
   (
      .clk           (clk),
      .rst           (rst),
      .restart       (!active),
      .ref_to_supply (zref_sync),
      .ref_resistor  (impedance_resistor),
      .impedance     (drive_impedance)
   );

   // Pin-side checks count edges from the request: register, latch, pins
   sleep_hiz_a: assert property (@(posedge clk) disable iff (rst) // see R24
      asleep |-> data_oe == '0)
      else $error("drivers on while asleep");
   write_off_a: assert property (@(posedge clk) disable iff (rst) // see R09
      $past(wr_q, 2) |-> data_oe == '0)
      else $error("drivers on after write");
   desel_off_a: assert property (@(posedge clk) disable iff (rst) // see R08
      !$past(sel_q, 2) |-> data_oe == '0)
      else $error("drivers on while deselected");
   wake_hold_a: assert property (@(posedge clk) disable iff (rst) // see R22
      $fell(asleep) |-> !sel_q [*2])
      else $error("access during recovery");
   empty_write_a: assert property (@(posedge clk) disable iff (rst) // see R16
      wr_q && active && lanes_q == '0 |=> !wbuf.valid)
      else $error("empty lane write buffered");
   late_data_a: assert property (@(posedge clk) disable iff (rst) // see R17
      wr_q && active |=> wbuf.data == $past(data_in) && wbuf.addr == $past(addr_q))
      else $error("late write capture wrong");
   fwd_read_a: assert property (@(posedge clk) disable iff (rst) // see R18
      rd_q && active && hit && wbuf.lanes == '1 |=> latch_word == $past(wbuf.data))
      else $error("buffered data not forwarded");
   oe_gate_a: assert property (@(posedge clk) disable iff (rst) // see R11
      oe_n_sync |=> data_oe == '0)
      else $error("drivers on with output enable high");
   read_on_a: assert property (@(posedge clk) disable iff (rst) // see R10
      $past(rd_q, 2) && $past(active, 2) && $past(active) && !$past(oe_n_sync)
      |-> data_oe == '1)
      else $error("drivers off for a read");
   read_data_a: assert property (@(posedge clk) disable iff (rst) // see R03 see R04
      $past(rd_q, 2) && $past(active, 2) |-> data_out == $past(fwd_word, 2))
      else $error("read word not presented");
   sleep_entry_a: assert property (@(posedge clk) disable iff (rst) // see R22
      pstate == lw_sram_pkg::PW_RUN && sleep_sync |=> pstate == lw_sram_pkg::PW_SLEEP)
      else $error("sleep not entered");
   wake_imp_a: assert property (@(posedge clk) disable iff (rst) // see R25
      !active |=> drive_impedance == lw_sram_pkg::IMP_DEFAULT)
      else $error("impedance not restarted");

   read_c: cover property (@(posedge clk) rd_q ##1 rd_q);
   write_read_c: cover property (@(posedge clk) wr_q ##1 rd_q && hit);
   sleep_c: cover property (@(posedge clk) asleep ##1 !asleep);
   part_fwd_c: cover property (@(posedge clk) rd_q && hit && wbuf.lanes != '1);
   empty_write_c: cover property (@(posedge clk) wr_q && lanes_q == '0);

endmodule // late_write_sync_sram_port

`default_nettype wire

/* verification/host_bus_model.sv */
`timescale 1ns/100ps
`default_nettype none

module host_bus_model
(
   input  wire logic                              clk,
   output logic                                   chip_select_n,
   output logic                                   write_strobe_n,
   output logic [lw_sram_pkg::LANES-1:0]          lane_write_enable_n,
   output logic [lw_sram_pkg::ADDR_BITS-1:0]      address_in,
   output logic [lw_sram_pkg::DATA_BITS-1:0]      data_in,
   output logic                                   output_enable_n,
   output logic                                   sleep_request
);
   logic [lw_sram_pkg::DATA_BITS-1:0] late_data;
   logic                              late_due;

   initial
   begin
      {chip_select_n, write_strobe_n, lane_write_enable_n} = '1;
      {address_in, data_in, late_data, late_due} = '0;
      {output_enable_n, sleep_request} = '0;
   end

   // Changes land just after the edge and hold for the whole cycle
   task automatic bus_cycle(input logic cs_n, input logic wr_n, input logic [3:0] ln,
                            input logic [7:0] a, input logic [35:0] wd);
      @(posedge clk);
      #1;
      {chip_select_n, write_strobe_n, lane_write_enable_n, address_in} = {cs_n, wr_n, ln, a};
      // Data trails its address by one edge; otherwise the bus keeps moving
      data_in = late_due ? late_data : ~data_in;
      late_due = !cs_n && !wr_n;
      late_data = wd;
   endtask

   task automatic set_misc(input logic oe_n, input logic slp);
      output_enable_n = oe_n;
      sleep_request = slp;
   endtask
endmodule // host_bus_model

`default_nettype wire

/* verification/late_write_sync_sram_port_tb.sv */
`timescale 1ns/100ps
`default_nettype none

module late_write_sync_sram_port_tb;
   localparam int W  = lw_sram_pkg::DATA_BITS;
   localparam int LB = lw_sram_pkg::LANE_BITS;
   wire logic         cs_n, wr_n, oe_n, slp;
   wire logic [3:0]   ln_n;
   wire logic [7:0]   addr;
   wire logic [W-1:0] din;
   logic      [W-1:0] dout, doe, last_d, model [16], slot_d [3];
   logic      [7:0]   res_code, imp;
   logic              clk, rst, ref_pin, asleep, oe_on, frozen, seen_def, slot_rd [3];
   int                mismatches, n_tests;

   host_bus_model host_u (.clk(clk), .chip_select_n(cs_n), .write_strobe_n(wr_n),
      .lane_write_enable_n(ln_n), .address_in(addr), .data_in(din),
      .output_enable_n(oe_n), .sleep_request(slp));

   late_write_sync_sram_port #(.ADDR_BITS(lw_sram_pkg::ADDR_BITS)) dut_u (.clk(clk),
      .rst(rst), .chip_select_n(cs_n), .write_strobe_n(wr_n), .lane_write_enable_n(ln_n),
      .address_in(addr), .data_in(din), .output_enable_n(oe_n), .sleep_request(slp),
      .impedance_ref_pin(ref_pin), .impedance_resistor(res_code), .data_out(dout),
      .data_oe(doe), .drive_impedance(imp), .asleep(asleep));

   initial
   begin
      clk = 0;
      forever #50 clk = ~clk;
   end

   function automatic logic [W-1:0] merge(input logic [W-1:0] o, input logic [W-1:0] n,
                                          input logic [3:0] ln);
      merge = o;
      for (int i = 0; i < lw_sram_pkg::LANES; i++)
         if (!ln[i]) merge[i*LB +: LB] = n[i*LB +: LB];
   endfunction

   task automatic check_data(input logic [W-1:0] got, input logic [W-1:0] exp, input string s);
      n_tests++;
      if (got !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, s, got, exp);
      end
   endtask

   task automatic check_small(input logic [7:0] got, input logic [7:0] exp, input string s);
      check_data(W'(got), W'(exp), s);
   endtask

   // One bus cycle; a read's word is judged three calls after it was issued
   task automatic step(input logic cs_n, input logic wr_n, input logic [3:0] ln,
                       input logic [7:0] a);
      logic [W-1:0] wd;
      logic         rd;
      wd = W'({$urandom, $urandom});
      rd = !cs_n && wr_n && !frozen;
      host_u.bus_cycle(cs_n, wr_n, ln, a, wd);
      if (slot_rd[2])
      begin
         last_d = slot_d[2];
         check_data(doe, {W{oe_on}}, "drive on");
      end
      else check_data(doe, '0, "drive off");
      check_data(dout, last_d, "read data");
      slot_rd[2] = slot_rd[1];
      slot_d[2] = slot_d[1];
      slot_rd[1] = slot_rd[0];
      slot_d[1] = slot_d[0];
      slot_rd[0] = rd;
      slot_d[0] = model[a[3:0]];
      if (!cs_n && !wr_n && !frozen) model[a[3:0]] = merge(model[a[3:0]], wd, ln);
   endtask

   task automatic idle(input int n);
      repeat (n)
      begin
         step(1, 1, '1, '0);
         seen_def |= (imp === lw_sram_pkg::IMP_DEFAULT);
      end
   endtask

   task automatic settle_imp(input logic [7:0] target);
      logic [7:0] last;
      int         n;
      n = 0;
      while (imp !== target && n < 3000)
      begin
         last = imp;
         idle(1);
         check_small(8'(imp == last || imp == last + 8'h01 || imp == last - 8'h01), 8'h01,
                     "impedance step");
         n++;
      end
      check_small(imp, target, "impedance");
   endtask

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial
   begin
      #(100 * 20000);
      mismatches++;
      give_verdict;
   end

   initial
   begin
      int         op;
      int         n;
      logic [3:0] ln;
      void'($urandom(86723));
      {mismatches, n_tests, frozen, seen_def} = '0;
      oe_on = 1;
      last_d = '0;
      slot_rd = '{default: 1'b0};
      rst = 1;
      ref_pin = 0;
      res_code = 8'hFA;
      repeat (5) @(posedge clk);
      #1 rst = 0;
      check_small(imp, lw_sram_pkg::IMP_DEFAULT, "reset impedance");
      check_data(doe, '0, "reset drive");
      check_small(8'(asleep), 8'h00, "reset sleep");
      for (int a = 0; a < 16; a++) step(0, 0, '0, 8'(a));
      step(0, 0, 4'h0, 8'h05);
      step(0, 1, 4'hF, 8'h05);
      step(0, 0, 4'hA, 8'h06);
      step(0, 1, 4'h0, 8'h06);
      step(0, 0, 4'hF, 8'h06);
      step(0, 1, 4'h5, 8'h06);
      step(0, 1, 4'h0, 8'h07);
      step(0, 0, 4'h3, 8'h07);
      step(0, 1, 4'h0, 8'h07);
      idle(3);
      $display("test corners done");
      for (int i = 0; i < 400; i++)
      begin
         op = $urandom_range(0, 9);
         ln = 4'($urandom);
         n = $urandom_range(0, 15);
         if (op < 5) step(0, 1, ln, 8'(n));
         else if (op < 8) step(0, 0, op[0] ? ln : '0, 8'(n));
         else if (op == 8) step(0, 0, '1, 8'(n));
         else step(1, 0, ln, 8'(n));
      end
      idle(3);
      $display("test random done");
      host_u.set_misc(1, 0);
      idle(4);
      oe_on = 0;
      repeat (6) step(0, 1, '0, 8'($urandom_range(0, 15)));
      idle(3);
      host_u.set_misc(0, 0);
      idle(4);
      oe_on = 1;
      $display("test output enable done");
      res_code = 8'(5 * $urandom_range(5, 50));
      settle_imp(8'(res_code / lw_sram_pkg::IMP_RATIO));
      ref_pin = 1;
      settle_imp(lw_sram_pkg::IMP_MIN);
      $display("test impedance done");
      idle(2);
      host_u.set_misc(0, 1);
      seen_def = 0;
      n = 0;
      while (asleep !== 1'b1 && n < 6)
      begin
         idle(1);
         n++;
      end
      check_small(8'(asleep), 8'h01, "sleep entry");
      frozen = 1;
      step(0, 0, '0, 8'h03);
      step(0, 1, '0, 8'h03);
      idle(3);
      host_u.set_misc(0, 0);
      idle(lw_sram_pkg::SLEEP_EXIT_CYC + 8);
      check_small(8'(asleep), 8'h00, "sleep exit");
      check_small(8'(seen_def), 8'h01, "impedance restart");
      frozen = 0;
      step(0, 1, '0, 8'h03);
      idle(3);
      $display("test sleep done");
      give_verdict;
   end
endmodule // late_write_sync_sram_port_tb

`default_nettype wire
